/* rtl/mcs_control_store.sv */
// Purpose: microcode control store, base ROM plus patch RAM and patch table
// Assumes: the sequencer runs on clk_sys and holds its address for one cycle
// Notes: the answer to an address comes from flops at the next edge
`timescale 1ns/10ps
`default_nettype none
module mcs_control_store #(
  parameter int ROM_WORDS = mcs_pkg::MCS_ROM_WORDS,
  parameter int RAM_WORDS = mcs_pkg::MCS_RAM_WORDS,
  parameter int CAM_ENTRIES = mcs_pkg::MCS_CAM_ENTRIES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire mcs_pkg::mcs_addr_t microwordAddressBus,
  output logic [mcs_pkg::MCS_WORD_W-1:0] microwordOut,
  output logic fetchAbort,
  output logic patchFetch,
  input wire logic patchWrEn,
  input wire mcs_pkg::mcs_ram_addr_t patchWrAddr,
  input wire mcs_pkg::mcs_word_t patchWrData,
  input wire logic camWrEn,
  input wire mcs_pkg::mcs_cam_idx_t camWrIndex,
  input wire mcs_pkg::mcs_rom_addr_t camWrAddr,
  input wire logic camWrValid
);
  import mcs_pkg::*;

  // ---------------------------------------------------------------
  // storage arrays
  // ---------------------------------------------------------------
  mcs_word_t patchMem [RAM_WORDS];

  mcs_word_t microwordReg;
  mcs_word_t microwordNext;
  logic abortReg;
  logic abortNext;
  logic patchReg;
  logic patchNext;

  // stand-in ROM image; a real part replaces this table at mask time
  function automatic mcs_word_t romContent(input mcs_rom_addr_t a);
    mcs_word_t w;
    w = {2'b00, a, 10'h000, a};
    return w ^ {a[9:0], 30'h0000_0000};
  endfunction

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // bit 14 and 13:10 all ones means patch space; else, with bit 14 low, the 14-bit ROM index below ROM_WORDS
  wire logic isPatch;
  wire logic isRom;
  wire logic inRomRange;
  wire mcs_rom_addr_t romAddr;
  wire mcs_ram_addr_t ramAddr;
  wire mcs_word_t romWord;
  wire mcs_word_t ramWord;
  wire logic camHit;

  assign isPatch = mcsIsPatch(microwordAddressBus);
  assign romAddr = microwordAddressBus[MCS_ROM_ADDR_W-1:0];
  assign inRomRange = (int'(romAddr) < ROM_WORDS);
  assign isRom = !isPatch && !microwordAddressBus[MCS_HIGH_MSB] && inRomRange;
  assign ramAddr = mcsLowBits(microwordAddressBus);
  assign romWord = romContent(romAddr);
  assign ramWord = patchMem[ramAddr];

  // ---------------------------------------------------------------
  // patch table
  // ---------------------------------------------------------------
  mcs_patch_cam #(
    .ENTRIES(CAM_ENTRIES)
  ) patchTable (
    .clk_sys(clk_sys),
    .rst(rst),
    .lookAddr(romAddr),
    .lookHit(camHit),
    .camWrEn(camWrEn),
    .camWrIndex(camWrIndex),
    .camWrAddr(camWrAddr),
    .camWrValid(camWrValid)
  );

  // ---------------------------------------------------------------
  // word select
  // ---------------------------------------------------------------
  // abort only on a ROM fetch; a patch fetch never aborts, so a patch
  // sequence runs until its last word jumps back to ROM
  assign abortNext = isRom && camHit;
  assign patchNext = isPatch;
  // the ROM word still goes out on an abort; the sequencer drops it
  assign microwordNext = isPatch ? ramWord : (isRom ? romWord : MCS_WORD_RESET);

  // ---------------------------------------------------------------
  // answer registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      microwordReg <= MCS_WORD_RESET;
      abortReg <= 1'b0;
      patchReg <= 1'b0;
    end else begin
      microwordReg <= microwordNext;
      abortReg <= abortNext;
      patchReg <= patchNext;
    end
  end

  // patch RAM load port, used by ROM microcode at power-up and later
  // by bootstrap software; a load and a fetch of the same word in one
  // cycle returns the old contents
  always_ff @(posedge clk_sys) begin
    if (patchWrEn) begin
      patchMem[patchWrAddr] <= patchWrData;
    end
  end

  assign microwordOut = microwordReg;
  assign fetchAbort = abortReg;
  assign patchFetch = patchReg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  abort_on_hit_a: assert property (@(posedge clk_sys) disable iff (rst)
    isRom && camHit |=> fetchAbort)
    else $error("table match did not abort the fetch");

  no_abort_miss_a: assert property (@(posedge clk_sys) disable iff (rst)
    !camHit || isPatch |=> !fetchAbort)
    else $error("abort raised without a ROM match");

  rom_word_a: assert property (@(posedge clk_sys) disable iff (rst)
    isRom |=> microwordOut == romContent($past(romAddr)))
    else $error("ROM word not returned one cycle after its address");

  patch_word_a: assert property (@(posedge clk_sys) disable iff (rst)
    isPatch |=> patchFetch && !fetchAbort && (microwordOut == $past(ramWord)))
    else $error("patch fetch returned wrong word or aborted");

  patch_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    patchWrEn ##1 (isPatch && ramAddr == $past(patchWrAddr) && !patchWrEn)
      |=> microwordOut == $past(patchWrData, 2))
    else $error("loaded patch word not seen by next patch fetch");

  alias_share_a: assert property (@(posedge clk_sys) disable iff (rst)
    isPatch |-> ramWord == patchMem[microwordAddressBus[MCS_LOW_MSB:0]])
    else $error("patch word not selected by low address bits");

  abort_cause_a: assert property (@(posedge clk_sys) disable iff (rst)
    fetchAbort |-> $past(isRom) && !patchFetch)
    else $error("abort not caused by a ROM fetch");
endmodule
`default_nettype wire

/* rtl/mcs_pkg.sv */
// Purpose: shared sizes, address fields and constants for the microcode control store
// Assumes: one clk_sys cycle stands for one CPU microcycle
// Notes: address bit 14 together with bits 13:10 select ROM or patch RAM space
package mcs_pkg;
  // ---------------------------------------------------------------
  // store sizes
  // ---------------------------------------------------------------
  localparam int MCS_ROM_WORDS = 15360;
  localparam int MCS_RAM_WORDS = 1024;
  localparam int MCS_CAM_ENTRIES = 160;
  localparam int MCS_WORD_W = 40;
  localparam int MCS_ROM_ADDR_W = 14;
  localparam int MCS_BUS_ADDR_W = 15;
  localparam int MCS_RAM_ADDR_W = 10;
  localparam int MCS_CAM_IDX_W = 8;

  // ---------------------------------------------------------------
  // address fields
  // ---------------------------------------------------------------
  localparam int MCS_LOW_MSB = 9;
  localparam int MCS_HIGH_LSB = 10;
  localparam int MCS_HIGH_MSB = 14;
  localparam logic [4:0] MCS_PATCH_SPACE = 5'h1f;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [MCS_WORD_W-1:0] MCS_WORD_RESET = 40'h00_0000_0000;

  typedef logic [MCS_WORD_W-1:0] mcs_word_t;
  typedef logic [MCS_BUS_ADDR_W-1:0] mcs_addr_t;
  typedef logic [MCS_ROM_ADDR_W-1:0] mcs_rom_addr_t;
  typedef logic [MCS_RAM_ADDR_W-1:0] mcs_ram_addr_t;
  typedef logic [MCS_CAM_IDX_W-1:0] mcs_cam_idx_t;

  // ---------------------------------------------------------------
  // address decode helpers
  // ---------------------------------------------------------------
  // patch space is marked by all ones on the high field
  function automatic logic mcsIsPatch(input mcs_addr_t a);
    return a[MCS_HIGH_MSB:MCS_HIGH_LSB] == MCS_PATCH_SPACE;
  endfunction

  function automatic mcs_ram_addr_t mcsLowBits(input mcs_addr_t a);
    return a[MCS_LOW_MSB:0];
  endfunction
endpackage

/* rtl/mcs_patch_cam.sv */
// Purpose: content-addressable table of patched ROM addresses
// Assumes: writes come from logic on clk_sys
// Notes: match is combinational; the caller registers the outcome
`timescale 1ns/10ps
`default_nettype none
module mcs_patch_cam #(
  parameter int ENTRIES = mcs_pkg::MCS_CAM_ENTRIES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire mcs_pkg::mcs_rom_addr_t lookAddr,
  output logic lookHit,
  input wire logic camWrEn,
  input wire mcs_pkg::mcs_cam_idx_t camWrIndex,
  input wire mcs_pkg::mcs_rom_addr_t camWrAddr,
  input wire logic camWrValid
);
  import mcs_pkg::*;

  mcs_rom_addr_t entryReg [ENTRIES];
  logic [ENTRIES-1:0] validReg;
  logic [ENTRIES-1:0] hitVec;
  logic [ENTRIES-1:0] aliasVec;
  logic [ENTRIES-1:0] validNext;
  logic aliasAny;
  mcs_cam_idx_t aliasIdx;

  // ---------------------------------------------------------------
  // compare and alias search
  // ---------------------------------------------------------------
  // a new entry sharing low bits with an older one evicts it, since
  // both would land on the same patch RAM word
  always_comb begin
    aliasAny = 1'b0;
    aliasIdx = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      hitVec[i] = validReg[i] && (entryReg[i] == lookAddr);
      aliasVec[i] = validReg[i] && (i != int'(camWrIndex)) &&
                    (entryReg[i][MCS_LOW_MSB:0] == camWrAddr[MCS_LOW_MSB:0]);
      if (aliasVec[i]) begin
        aliasAny = 1'b1;
        aliasIdx = mcs_cam_idx_t'(i);
      end
    end
  end

  assign lookHit = |hitVec;

  // valid bits: the written entry takes its flag, aliases drop out when that flag is set
  always_comb begin
    validNext = validReg;
    if (camWrEn) begin
      if (camWrValid) begin
        validNext = validReg & ~aliasVec;
      end
      validNext[camWrIndex] = camWrValid;
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // every entry starts invalid so base microcode runs unpatched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      validReg <= '0;
    end else begin
      validReg <= validNext;
    end
  end

  // entry addresses need no reset, the valid bit guards them
  always_ff @(posedge clk_sys) begin
    if (camWrEn) begin
      entryReg[camWrIndex] <= camWrAddr;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  cam_write_hit_a: assert property (@(posedge clk_sys) disable iff (rst)
    camWrEn && camWrValid && (int'(camWrIndex) < ENTRIES) |=> validReg[$past(camWrIndex)] &&
      (entryReg[$past(camWrIndex)] == $past(camWrAddr)))
    else $error("written table entry not valid with its address");

  alias_evict_a: assert property (@(posedge clk_sys) disable iff (rst)
    camWrEn && camWrValid && aliasAny |=> !validReg[$past(aliasIdx)])
    else $error("aliasing table entry survived a new install");

  hit_needs_valid_a: assert property (@(posedge clk_sys) disable iff (rst)
    lookHit |-> (validReg != '0))
    else $error("table hit with no valid entry");
endmodule
`default_nettype wire

/* verification/mcs_seq_model.sv */
// Purpose: behavioural microsequencer on the far side of the store
// Assumes: answers land at clk_sys edges; the bus moves 1 ns later
// Notes: patch word bit 39 marks the last word, bits 13:0 its return address
`timescale 1ns/10ps
`default_nettype none
module mcs_seq_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire mcs_pkg::mcs_word_t microwordOut,
  input wire logic fetchAbort,
  input wire logic patchFetch,
  input wire logic jumpEn,
  input wire mcs_pkg::mcs_rom_addr_t jumpAddr,
  output var mcs_pkg::mcs_addr_t microwordAddressBus
);
  import mcs_pkg::*;
  logic jumpSeen;
  mcs_rom_addr_t jumpDest;
  initial microwordAddressBus = '0;
  // pick the next address once this edge's answer has settled
  always @(posedge clk_sys) begin
    jumpSeen = jumpEn;
    jumpDest = jumpAddr;
    #1;
    if (rst) begin
      microwordAddressBus = '0;
    end else if (fetchAbort) begin
      microwordAddressBus = {MCS_PATCH_SPACE, microwordAddressBus[MCS_LOW_MSB:0]};
    end else if (patchFetch && microwordOut[MCS_WORD_W-1]) begin
      microwordAddressBus = {1'b0, microwordOut[MCS_ROM_ADDR_W-1:0]};
    end else if (patchFetch) begin
      microwordAddressBus = {MCS_PATCH_SPACE, microwordAddressBus[MCS_LOW_MSB:0] + 10'h1};
    end else if (jumpSeen) begin
      microwordAddressBus = {1'b0, jumpDest};
    end
    // else the word is taken as is; holding keeps idle fetches harmless
  end
endmodule
`default_nettype wire

/* verification/mcs_control_store_tb.sv */
// Purpose: self-checking bench for the microcode control store
// Assumes: inputs move 1 ns after each rising edge
// Notes: the bench plays the loader that fills patch RAM and table
`timescale 1ns/10ps
`default_nettype none
module mcs_control_store_tb;
  import mcs_pkg::*;
  logic clk_sys, rst, fetchAbort, patchFetch, patchWrEn, camWrEn, camWrValid, jumpEn;
  mcs_addr_t microwordAddressBus;
  mcs_word_t microwordOut, patchWrData;
  mcs_ram_addr_t patchWrAddr;
  mcs_cam_idx_t camWrIndex;
  mcs_rom_addr_t camWrAddr, jumpAddr;
  int errTotal, samplesChecked;
  mcs_control_store dut_u (.clk_sys(clk_sys), .rst(rst), .microwordAddressBus(microwordAddressBus),
    .microwordOut(microwordOut), .fetchAbort(fetchAbort), .patchFetch(patchFetch),
    .patchWrEn(patchWrEn), .patchWrAddr(patchWrAddr), .patchWrData(patchWrData), .camWrEn(camWrEn),
    .camWrIndex(camWrIndex), .camWrAddr(camWrAddr), .camWrValid(camWrValid));
  mcs_seq_model seq_u (.clk_sys(clk_sys), .rst(rst), .microwordOut(microwordOut), .fetchAbort(fetchAbort),
    .patchFetch(patchFetch), .jumpEn(jumpEn), .jumpAddr(jumpAddr), .microwordAddressBus(microwordAddressBus));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic mcs_word_t romW(input mcs_rom_addr_t a);
    return {2'b00, a, 10'h0, a} ^ {a[9:0], 30'h0};
  endfunction
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic see(input mcs_word_t w, input logic ab, input logic pf);
    samplesChecked++;
    if (microwordOut !== w || fetchAbort !== ab || patchFetch !== pf) begin
      errTotal++;
      $display("Error %0t: got %h abort %b patch %b", $time, microwordOut, fetchAbort, patchFetch);
    end
  endtask
  // enables stay high between calls so back-to-back loads never glitch
  task automatic ram(input mcs_ram_addr_t a, input mcs_word_t d);
    patchWrAddr = a;
    patchWrData = d;
    patchWrEn = 1'b1;
    tick();
  endtask
  task automatic cam(input mcs_cam_idx_t i, input mcs_rom_addr_t a, input logic v);
    camWrIndex = i;
    camWrAddr = a;
    camWrValid = v;
    camWrEn = 1'b1;
    tick();
  endtask
  task automatic quiet;
    patchWrEn = 1'b0;
    camWrEn = 1'b0;
  endtask
  // returns when the answer to the jumped-to address is on the outputs
  task automatic jump(input mcs_rom_addr_t a);
    jumpAddr = a;
    jumpEn = 1'b1;
    tick();
    jumpEn = 1'b0;
    tick();
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic testBoundary;
    jump(14'h3bff);
    see(romW(14'h3bff), 1'b0, 1'b0);
    jump(14'h3c00);
    see('0, 1'b0, 1'b0);
    $display("boundary test done");
  endtask
  task automatic testPatchWalk;
    ram(10'h35c, 40'h00_1234_5678);
    ram(10'h35d, 40'h00_0abc_def0);
    ram(10'h35e, 40'h80_0000_0100);
    quiet();
    cam(8'h00, 14'h35c, 1'b1);
    quiet();
    jump(14'h35c);
    see(romW(14'h35c), 1'b1, 1'b0);
    tick();
    see(40'h00_1234_5678, 1'b0, 1'b1);
    tick();
    see(40'h00_0abc_def0, 1'b0, 1'b1);
    tick();
    see(40'h80_0000_0100, 1'b0, 1'b1);
    tick();
    see(romW(14'h100), 1'b0, 1'b0);
    $display("patch walk test done");
  endtask
  task automatic testAlias;
    cam(8'h01, 14'hb5c, 1'b1);
    quiet();
    jump(14'h35c);
    see(romW(14'h35c), 1'b0, 1'b0);
    jump(14'hb5c);
    see(romW(14'hb5c), 1'b1, 1'b0);
    // reload the next patch word while the walk is on its way to it
    ram(10'h35d, 40'h00_5a5a_5a5a);
    quiet();
    see(40'h00_1234_5678, 1'b0, 1'b1);
    tick();
    see(40'h00_5a5a_5a5a, 1'b0, 1'b1);
    repeat (2) tick();
    $display("alias test done");
  endtask
  task automatic testTableEdge;
    ram(10'h200, 40'h80_0000_0100);
    quiet();
    cam(8'ha0, 14'h200, 1'b1);
    quiet();
    jump(14'h200);
    see(romW(14'h200), 1'b0, 1'b0);
    cam(8'h9f, 14'h200, 1'b1);
    quiet();
    tick();
    see(romW(14'h200), 1'b1, 1'b0);
    tick();
    see(40'h80_0000_0100, 1'b0, 1'b1);
    tick();
    cam(8'h9f, 14'h200, 1'b0);
    quiet();
    jump(14'h200);
    see(romW(14'h200), 1'b0, 1'b0);
    $display("table edge test done");
  endtask
  task automatic testReset;
    rst = 1'b1;
    tick();
    see('0, 1'b0, 1'b0);
    rst = 1'b0;
    jump(14'hb5c);
    see(romW(14'hb5c), 1'b0, 1'b0);
    $display("reset test done");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {rst, patchWrEn, camWrEn, camWrValid, jumpEn} = 5'h10;
    {patchWrAddr, patchWrData, camWrIndex, camWrAddr, jumpAddr} = '0;
    errTotal = 0;
    samplesChecked = 0;
    repeat (5) @(posedge clk_sys);
    #1;
    see('0, 1'b0, 1'b0);
    rst = 1'b0;
    testBoundary();
    testPatchWalk();
    testAlias();
    testTableEdge();
    testReset();
    summarize();
  end
  // watchdog: the tests need well under 200 cycles
  initial begin
    repeat (1000) @(posedge clk_sys);
    errTotal++;
    summarize();
  end
endmodule
`default_nettype wire
